/* hdl/io_config_register_bank.sv */
/*
  Byte-wide control and status register bank for seven 8-bit I/O ports,
  power control, page and memory mapping.
  Assumes host strobes and pins are synchronous to sys_clk.
*/
// Behaviour
// - Registers decode at fixed offsets within a 256-byte window at a user base.
// - Pin input registers are read-only and return the current pin levels.
// - Output latch stores host byte; bit n drives pin n when output.
// - Direction bit 0 makes pin input (reset value), 1 makes it output.
// - Ports E, F, G address-out select: 0 keeps I/O, 1 outputs latched address.
// - Ports A, B, D, E, G driver bit: 0 push-pull, 1 open-drain.
// - Ports C, F driver bit: 0 push-pull, 1 fast slew rate.
// - Main lock register read-only, bit i set when main sector i is protected.
// - Secondary lock bits 3..0 read set when that secondary sector is protected.
// - Secondary lock bit 7 shows security lock; bits 6..4 read zero.
// - Page register feeds its value to logic; resets to 00.
// - Power control 0: bit1 auto power down, bit3 turbo off, bits4,5 clock off.
// - Power control 2 bits 2..6 disconnect control, latch and high-write inputs.
module io_config_register_bank
  import io_config_pkg::*;
(
  input  wire logic                                 sys_clk,
  input  wire logic                                 arst_n,
  input  wire logic [7:0]                           window_base,
  input  wire logic [15:0]                          host_addr,
  input  wire logic                                 host_wr,
  input  wire logic                                 host_rd,
  input  wire logic [7:0]                           host_wdata,
  output logic      [7:0]                           host_rdata,
  input  wire logic [io_config_pkg::NUM_PORTS-1:0][7:0]    pin_in,
  input  wire logic [io_config_pkg::NUM_ADDR_OUT-1:0][7:0] latched_addr,
  output logic      [io_config_pkg::NUM_PORTS-1:0][7:0]    pin_out,
  output logic      [io_config_pkg::NUM_PORTS-1:0][7:0]    pin_oe,
  output logic      [io_config_pkg::NUM_PORTS-1:0][7:0]    fast_slew,
  input  wire logic [7:0]                           main_sector_prot,
  input  wire logic [3:0]                           secondary_sector_prot,
  input  wire logic                                 security_set,
  output logic      [7:0]                           page_out,
  output logic      [7:0]                           power_control_0,
  output logic      [7:0]                           power_control_2,
  output logic      [4:0]                           memory_space_map
);
  import io_config_pkg::*;

  // ****************************************************************
  // Window decode
  // ****************************************************************
  logic [NUM_PORTS-1:0][7:0]    output_latch;
  logic [NUM_PORTS-1:0][7:0]    pin_direction;
  logic [NUM_PORTS-1:0][7:0]    driver_type;
  logic [NUM_ADDR_OUT-1:0][7:0] addr_out_select;
  logic [NUM_PORTS-1:0]         hit_in;
  logic [NUM_PORTS-1:0]         hit_out;
  logic [NUM_PORTS-1:0]         hit_dir;
  logic [NUM_PORTS-1:0]         hit_drv;
  logic [NUM_ADDR_OUT-1:0]      hit_sel;
  logic [7:0]                   next_rdata;
  logic [NUM_PORTS-1:0][7:0]    next_pin_out;
  logic [NUM_PORTS-1:0][7:0]    next_pin_oe;
  logic [NUM_PORTS-1:0][7:0]    next_fast_slew;
  logic [7:0]                   ofs;
  logic                         in_window;
  logic                         wr_en;

  assign in_window = host_addr[15:8] == window_base;
  assign ofs       = host_addr[7:0];
  assign wr_en     = host_wr && in_window;

  function automatic logic [7:0] drive_byte(input logic [7:0] sel, input logic [7:0] a,
                                            input logic [7:0] b);
    drive_byte = (sel & a) | (~sel & b);
  endfunction : drive_byte

  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    logic [7:0] src;
    logic [7:0] sel;
    logic [7:0] od;
    assign hit_in[p]  = ofs == OFS_PIN_INPUT[p];
    assign hit_out[p] = ofs == OFS_OUTPUT_LATCH[p];
    assign hit_dir[p] = ofs == OFS_PIN_DIRECTION[p];
    assign hit_drv[p] = ofs == OFS_DRIVER_TYPE[p];
    if (p >= FIRST_ADDR_OUT_PORT) begin : g_addr
      assign sel = addr_out_select[p-FIRST_ADDR_OUT_PORT];
      assign src = drive_byte(sel, latched_addr[p-FIRST_ADDR_OUT_PORT],
                              output_latch[p]);
    end else begin : g_plain
      assign sel = 8'h00;
      assign src = output_latch[p];
    end
    // Driver byte means fast slew on ports C and F, open drain elsewhere.
    assign od = SLEW_PORT_MASK[p] ? 8'h00 : driver_type[p];
    assign next_fast_slew[p] = SLEW_PORT_MASK[p] ? driver_type[p] : 8'h00;
    assign next_pin_out[p]   = src;
    // An open-drain pin only drives while its value is low.
    assign next_pin_oe[p]    = (pin_direction[p] | sel) & ~(od & src);
  end

  for (genvar s = 0; s < NUM_ADDR_OUT; s++) begin : g_sel_hit
    assign hit_sel[s] = ofs == OFS_ADDR_OUT_SELECT[s];
  end

  // ****************************************************************
  // Read multiplexer
  // ****************************************************************
  always_comb begin
    next_rdata = 8'h00;
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (hit_in[p]) begin
        next_rdata = pin_in[p];
      end else if (hit_out[p]) begin
        next_rdata = output_latch[p];
      end else if (hit_dir[p]) begin
        next_rdata = pin_direction[p];
      end else if (hit_drv[p]) begin
        next_rdata = driver_type[p];
      end
    end
    for (int s = 0; s < NUM_ADDR_OUT; s++) begin
      if (hit_sel[s]) begin
        next_rdata = addr_out_select[s];
      end
    end
    if (ofs == OFS_POWER_CONTROL_0) begin
      next_rdata = power_control_0;
    end else if (ofs == OFS_POWER_CONTROL_2) begin
      next_rdata = power_control_2;
    end else if (ofs == OFS_MAIN_LOCK) begin
      next_rdata = main_sector_prot;
    end else if (ofs == OFS_SECONDARY_LOCK) begin
      next_rdata = {security_set, 3'b000, secondary_sector_prot};
    end else if (ofs == OFS_PAGE_SELECT) begin
      next_rdata = page_out;
    end else if (ofs == OFS_MEMORY_MAP) begin
      next_rdata = {3'b000, memory_space_map};
    end else if (ofs == OFS_SIZE_INFO_0) begin
      next_rdata = SIZE_INFO_0;
    end else if (ofs == OFS_SIZE_INFO_1) begin
      next_rdata = SIZE_INFO_1;
    end
    if (!in_window) begin
      next_rdata = 8'h00;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Read data holds its last value between reads so a slow host can sample late.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      host_rdata <= 8'h00;
    end else if (host_rd) begin
      host_rdata <= next_rdata;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      output_latch  <= {NUM_PORTS{RST_PORT_REG}};
      pin_direction <= {NUM_PORTS{RST_PORT_REG}};
      driver_type   <= {NUM_PORTS{RST_PORT_REG}};
    end else if (wr_en) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (hit_out[p]) begin
          output_latch[p] <= host_wdata;
        end
        if (hit_dir[p]) begin
          pin_direction[p] <= host_wdata;
        end
        if (hit_drv[p]) begin
          driver_type[p] <= host_wdata;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      addr_out_select <= {NUM_ADDR_OUT{RST_PORT_REG}};
    end else if (wr_en) begin
      for (int s = 0; s < NUM_ADDR_OUT; s++) begin
        if (hit_sel[s]) begin
          addr_out_select[s] <= host_wdata;
        end
      end
    end
  end

  // Lock and size registers have no write path, so writes to them vanish.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      power_control_0  <= RST_POWER;
      power_control_2  <= RST_POWER;
      page_out         <= RST_PAGE;
      memory_space_map <= RST_MEMORY_MAP[4:0];
    end else if (wr_en) begin
      if (ofs == OFS_POWER_CONTROL_0) begin
        power_control_0 <= host_wdata & PC0_MASK;
      end
      if (ofs == OFS_POWER_CONTROL_2) begin
        power_control_2 <= host_wdata & PC2_MASK;
      end
      if (ofs == OFS_PAGE_SELECT) begin
        page_out <= host_wdata;
      end
      if (ofs == OFS_MEMORY_MAP) begin
        memory_space_map <= host_wdata[4:0] & MAP_MASK[4:0];
      end
    end
  end

  // Pins follow the configuration one cycle later, keeping every output a flop.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_out   <= '0;
      pin_oe    <= '0;
      fast_slew <= '0;
    end else begin
      pin_out   <= next_pin_out;
      pin_oe    <= next_pin_oe;
      fast_slew <= next_fast_slew;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  a_window_miss: assert property (host_rd && !in_window |=> host_rdata == 8'h00)
    else $error("read outside window returned data");
  a_pin_read: assert property (host_rd && in_window && ofs == OFS_PIN_INPUT[0]
    |=> host_rdata == $past(pin_in[0]))
    else $error("pin input read mismatch");
  a_latch_drive: assert property (wr_en && ofs == OFS_OUTPUT_LATCH[0]
    |=> ##1 pin_out[0] == $past(host_wdata, 2))
    else $error("output latch not driven to pin");
  a_dir_input: assert property (pin_direction[1] == 8'h00 |=> pin_oe[1] == 8'h00)
    else $error("input pin is driven");
  // Checked bit by bit so that a partly selected byte is covered as well.
  a_addr_select: assert property (
    1'b1 |=> ((pin_out[4] ^ $past(latched_addr[0])) & $past(addr_out_select[0])) == 8'h00)
    else $error("address out not on port pins");
  a_open_drain: assert property (
    1'b1 |=> (pin_oe[0] & pin_out[0] & $past(driver_type[0])) == 8'h00)
    else $error("open drain pin drove high");
  a_slew_ports: assert property (fast_slew[0] == 8'h00 && fast_slew[6] == 8'h00)
    else $error("slew select on wrong port");
  a_lock_read: assert property (host_rd && in_window && ofs == OFS_SECONDARY_LOCK
    |=> host_rdata[6:4] == 3'b000 && host_rdata[7] == $past(security_set))
    else $error("secondary lock read wrong");
  a_page_write: assert property (wr_en && ofs == OFS_PAGE_SELECT
    |=> page_out == $past(host_wdata))
    else $error("page register not written");
  a_power_mask: assert property ((power_control_0 & ~PC0_MASK) == 8'h00
    && (power_control_2 & ~PC2_MASK) == 8'h00)
    else $error("unused power bits set");
  a_ro_ignore: assert property (wr_en && ofs == OFS_MAIN_LOCK
    |=> $stable(page_out) && $stable(power_control_0))
    else $error("write to lock register had side effect");

  // ****************************************************************
  // Assertions per port and per address-out select
  // ****************************************************************
  // One copy per port, so that a decode slip on one offset shows by its index.
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port_check
    a_latch_write: assert property (
      wr_en && hit_out[p] |=> output_latch[p] == $past(host_wdata))
      else $error("output latch write lost");
    a_dir_write: assert property (
      wr_en && hit_dir[p] |=> pin_direction[p] == $past(host_wdata))
      else $error("direction write lost");
    a_drv_write: assert property (
      wr_en && hit_drv[p] |=> driver_type[p] == $past(host_wdata))
      else $error("driver type write lost");
    a_input_ignore: assert property (
      wr_en && hit_in[p] |=> $stable(output_latch) && $stable(pin_direction)
      && $stable(driver_type))
      else $error("write to pin input changed a register");
    a_oe_direction: assert property (
      1'b1 |=> (pin_oe[p] & ~$past(pin_direction[p]) & ~$past(g_port[p].sel)) == 8'h00)
      else $error("input pin is driven");
    a_od_no_high: assert property (
      1'b1 |=> (pin_oe[p] & pin_out[p] & $past(g_port[p].od)) == 8'h00)
      else $error("open drain pin drove high");
    a_slew_map: assert property (
      1'b1 |=> fast_slew[p] == (SLEW_PORT_MASK[p] ? $past(driver_type[p]) : 8'h00))
      else $error("fast slew on wrong port");
    a_read_pin: assert property (
      host_rd && in_window && hit_in[p] |=> host_rdata == $past(pin_in[p]))
      else $error("pin input read mismatch");
    a_read_latch: assert property (
      host_rd && in_window && hit_out[p] |=> host_rdata == $past(output_latch[p]))
      else $error("output latch read mismatch");
    a_read_dir: assert property (
      host_rd && in_window && hit_dir[p] |=> host_rdata == $past(pin_direction[p]))
      else $error("direction read mismatch");
    a_read_drv: assert property (
      host_rd && in_window && hit_drv[p] |=> host_rdata == $past(driver_type[p]))
      else $error("driver type read mismatch");
  end

  for (genvar s = 0; s < NUM_ADDR_OUT; s++) begin : g_sel_check
    a_sel_write: assert property (
      wr_en && hit_sel[s] |=> addr_out_select[s] == $past(host_wdata))
      else $error("address out select write lost");
    a_sel_read: assert property (
      host_rd && in_window && hit_sel[s] |=> host_rdata == $past(addr_out_select[s]))
      else $error("address out select read mismatch");
    a_sel_value: assert property (
      1'b1 |=> ((pin_out[s+FIRST_ADDR_OUT_PORT] ^ $past(latched_addr[s]))
      & $past(addr_out_select[s])) == 8'h00)
      else $error("address out byte not on pins");
  end

  // ****************************************************************
  // Assertions on the shared registers
  // ****************************************************************
  a_pc0_write: assert property (
    wr_en && ofs == OFS_POWER_CONTROL_0 |=> power_control_0 == ($past(host_wdata) & PC0_MASK))
    else $error("power control 0 write lost");
  a_pc2_write: assert property (
    wr_en && ofs == OFS_POWER_CONTROL_2 |=> power_control_2 == ($past(host_wdata) & PC2_MASK))
    else $error("power control 2 write lost");
  a_pc0_read: assert property (
    host_rd && in_window && ofs == OFS_POWER_CONTROL_0 |=> host_rdata == $past(power_control_0))
    else $error("power control 0 read mismatch");
  a_map_write: assert property (
    wr_en && ofs == OFS_MEMORY_MAP |=> memory_space_map == $past(host_wdata[4:0]))
    else $error("memory map write lost");
  a_map_read: assert property (
    host_rd && in_window && ofs == OFS_MEMORY_MAP |=> host_rdata[7:5] == 3'b000)
    else $error("memory map unused bits set");
  a_page_read: assert property (
    host_rd && in_window && ofs == OFS_PAGE_SELECT |=> host_rdata == $past(page_out))
    else $error("page register read mismatch");
  a_page_hold: assert property (
    !(wr_en && ofs == OFS_PAGE_SELECT) |=> $stable(page_out))
    else $error("page register changed without a write");
  a_main_read: assert property (
    host_rd && in_window && ofs == OFS_MAIN_LOCK |=> host_rdata == $past(main_sector_prot))
    else $error("main lock read mismatch");
  a_sec_read: assert property (
    host_rd && in_window && ofs == OFS_SECONDARY_LOCK
    |=> host_rdata[3:0] == $past(secondary_sector_prot))
    else $error("secondary lock bits read wrong");
  a_size_read: assert property (
    host_rd && in_window && ofs == OFS_SIZE_INFO_0 |=> host_rdata == SIZE_INFO_0)
    else $error("size info read mismatch");
  a_unmapped_read: assert property (
    host_rd && in_window && ofs == 8'h02 |=> host_rdata == 8'h00)
    else $error("unmapped offset returned data");
  // A write for another window must leave page_out and the output latches of this one alone.
  a_wr_outside: assert property (
    host_wr && !in_window |=> $stable(page_out) && $stable(output_latch))
    else $error("write outside window took effect");

  c_port_write: cover property (wr_en && hit_out[0] ##1 host_rd && hit_in[0]);
  c_addr_mode: cover property (addr_out_select[2] != 8'h00);
  c_page_read: cover property (wr_en && ofs == OFS_PAGE_SELECT ##1 host_rd);
  c_open_drain: cover property (driver_type[0] != 8'h00 && pin_oe[0] != 8'hff);
  c_lock_write: cover property (wr_en && ofs == OFS_MAIN_LOCK);

endmodule : io_config_register_bank

/* shared/io_config_pkg.sv */
/*
  Offsets, field positions and reset values of the I/O configuration register bank.
  Assumes an 8-bit host data bus and a 256-byte register window.
*/
package io_config_pkg;

  // ****************************************************************
  // Geometry
  // ****************************************************************
  localparam int NUM_PORTS = 7;
  localparam int NUM_ADDR_OUT = 3;
  localparam int FIRST_ADDR_OUT_PORT = 4;
  localparam logic [6:0] SLEW_PORT_MASK = 7'h24;

  // ****************************************************************
  // Offsets inside the window, index 0 is port A
  // ****************************************************************
  localparam logic [7:0] OFS_PIN_INPUT [NUM_PORTS] =
    '{8'h00, 8'h01, 8'h10, 8'h11, 8'h30, 8'h40, 8'h41};
  localparam logic [7:0] OFS_OUTPUT_LATCH [NUM_PORTS] =
    '{8'h04, 8'h05, 8'h14, 8'h15, 8'h34, 8'h44, 8'h45};
  localparam logic [7:0] OFS_PIN_DIRECTION [NUM_PORTS] =
    '{8'h06, 8'h07, 8'h16, 8'h17, 8'h36, 8'h46, 8'h47};
  localparam logic [7:0] OFS_DRIVER_TYPE [NUM_PORTS] =
    '{8'h08, 8'h09, 8'h18, 8'h19, 8'h38, 8'h48, 8'h49};
  localparam logic [7:0] OFS_ADDR_OUT_SELECT [NUM_ADDR_OUT] = '{8'h32, 8'h42, 8'h43};
  localparam logic [7:0] OFS_POWER_CONTROL_0 = 8'hb0;
  localparam logic [7:0] OFS_POWER_CONTROL_2 = 8'hb4;
  localparam logic [7:0] OFS_MAIN_LOCK       = 8'hc0;
  localparam logic [7:0] OFS_SECONDARY_LOCK  = 8'hc2;
  localparam logic [7:0] OFS_PAGE_SELECT     = 8'he0;
  localparam logic [7:0] OFS_MEMORY_MAP      = 8'he2;
  localparam logic [7:0] OFS_SIZE_INFO_0     = 8'hf0;
  localparam logic [7:0] OFS_SIZE_INFO_1     = 8'hf1;

  // ****************************************************************
  // Field positions and writable masks
  // ****************************************************************
  localparam int PC0_AUTO_POWER_DOWN = 1;
  localparam int PC0_TURBO_OFF       = 3;
  localparam int PC0_ARRAY_CLK_OFF   = 4;
  localparam int PC0_MCELL_CLK_OFF   = 5;
  localparam int PC2_ADDR_LOW_OFF    = 0;
  localparam int PC2_INPUT_OFF_LSB   = 2;
  localparam int SEC_SECURITY_BIT    = 7;
  localparam logic [7:0] PC0_MASK = 8'h3a;
  localparam logic [7:0] PC2_MASK = 8'h7d;
  localparam logic [7:0] MAP_MASK = 8'h1f;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] RST_PORT_REG   = 8'h00;
  localparam logic [7:0] RST_POWER      = 8'h00;
  localparam logic [7:0] RST_PAGE       = 8'h00;
  localparam logic [7:0] RST_MEMORY_MAP = 8'h00;
  localparam logic [7:0] SIZE_INFO_0    = 8'h00;
  localparam logic [7:0] SIZE_INFO_1    = 8'h00;

endpackage : io_config_pkg

/* testbench/host_bus_model.sv */
/*
  Host microcontroller model: byte write and read cycles on the register window bus.
  Assumes the bench calls its tasks and that the bank samples strobes on sys_clk.
*/
module host_bus_model (
  input  wire logic        sys_clk,
  output logic      [15:0] host_addr,
  output logic             host_wr,
  output logic             host_rd,
  output logic      [7:0]  host_wdata,
  input  wire logic [7:0]  host_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    host_addr = 16'h0000;
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_wdata = 8'h00;
  end

  // ****************************************************************
  // Bus cycles
  // ****************************************************************
  // After a cycle the address lines, and after a write the data lines too, show the inverse
  // of their last value, so a stale byte can never pass for a fresh one.
  task automatic write_byte(input logic [15:0] addr, input logic [7:0] data);
    @(posedge sys_clk);
    #2;
    host_addr = addr;
    host_wdata = data;
    host_wr = 1'b1;
    @(posedge sys_clk);
    #2;
    host_wr = 1'b0;
    host_addr = ~addr;
    host_wdata = ~data;
  endtask : write_byte

  task automatic read_byte(input logic [15:0] addr, output logic [7:0] data);
    @(posedge sys_clk);
    #2;
    host_addr = addr;
    host_rd = 1'b1;
    @(posedge sys_clk);
    #2;
    data = host_rdata;
    host_rd = 1'b0;
    host_addr = ~addr;
  endtask : read_byte
endmodule : host_bus_model

/* testbench/io_config_register_bank_test.sv */
/*
  Self-checking bench of the I/O configuration register bank.
  Assumes host_bus_model for bus cycles and a single 20 MHz clock.
*/
module io_config_register_bank_test
  import io_config_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] BASE = 8'h7c;
  logic                        sys_clk = 1'b0;
  logic                        arst_n = 1'b0;
  logic [7:0]                  window_base = BASE;
  logic [15:0]                 host_addr;
  logic                        host_wr, host_rd, security_set = 1'b0;
  logic [7:0]                  host_wdata, host_rdata, page_out;
  logic [7:0]                  power_control_0, power_control_2, main_sector_prot = 8'h00;
  logic [3:0]                  secondary_sector_prot = 4'h0;
  logic [4:0]                  memory_space_map;
  logic [NUM_PORTS-1:0][7:0]   pin_in = '0, pin_out, pin_oe, fast_slew;
  logic [NUM_ADDR_OUT-1:0][7:0] latched_addr = '0;
  int                          fails = 0;
  int                          cmp_count = 0;

  always #25 sys_clk = ~sys_clk;

  io_config_register_bank i_io_config_register_bank (.sys_clk, .arst_n, .window_base,
    .host_addr, .host_wr, .host_rd, .host_wdata, .host_rdata, .pin_in, .latched_addr,
    .pin_out, .pin_oe, .fast_slew, .main_sector_prot, .secondary_sector_prot,
    .security_set, .page_out, .power_control_0, .power_control_2, .memory_space_map);
  host_bus_model i_host_bus_model (.sys_clk, .host_addr, .host_wr, .host_rd,
    .host_wdata, .host_rdata);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check8
  task automatic wr(input logic [7:0] ofs, input logic [7:0] data);
    i_host_bus_model.write_byte({BASE, ofs}, data);
  endtask : wr
  task automatic rd_check(input logic [7:0] ofs, input logic [7:0] exp);
    logic [7:0] got;
    i_host_bus_model.read_byte({BASE, ofs}, got);
    check8(got, exp);
  endtask : rd_check
  // Port outputs trail a configuration write by two edges.
  task automatic settle();
    repeat (2) @(posedge sys_clk);
    #2;
  endtask : settle

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic test_reset();
    for (int p = 0; p < NUM_PORTS; p++) begin
      check8(pin_oe[p], 8'h00);
      rd_check(OFS_PIN_DIRECTION[p], 8'h00);
    end
    rd_check(OFS_PAGE_SELECT, 8'h00);
    rd_check(OFS_POWER_CONTROL_0, 8'h00);
    rd_check(OFS_POWER_CONTROL_2, 8'h00);
    $display("test_reset done");
  endtask : test_reset
  task automatic test_ports();
    for (int p = 0; p < NUM_PORTS; p++) pin_in[p] = 8'h3c ^ 8'(p);
    for (int p = 0; p < NUM_PORTS; p++) begin
      rd_check(OFS_PIN_INPUT[p], 8'h3c ^ 8'(p));
      wr(OFS_PIN_DIRECTION[p], 8'hff);
      wr(OFS_OUTPUT_LATCH[p], 8'h96 ^ 8'(p));
      settle();
      check8(pin_out[p], 8'h96 ^ 8'(p));
      check8(pin_oe[p], 8'hff);
      rd_check(OFS_OUTPUT_LATCH[p], 8'h96 ^ 8'(p));
    end
    wr(OFS_PIN_DIRECTION[1], 8'h0f);
    settle();
    check8(pin_oe[1], 8'h0f);
    $display("test_ports done");
  endtask : test_ports
  task automatic test_drive();
    wr(OFS_OUTPUT_LATCH[0], 8'h55);
    wr(OFS_DRIVER_TYPE[0], 8'h0f);
    wr(OFS_DRIVER_TYPE[2], 8'ha5);
    settle();
    check8(pin_oe[0], 8'hfa);
    check8(fast_slew[0], 8'h00);
    check8(fast_slew[2], 8'ha5);
    check8(pin_oe[2], 8'hff);
    rd_check(OFS_DRIVER_TYPE[0], 8'h0f);
    $display("test_drive done");
  endtask : test_drive
  task automatic test_addr_out();
    for (int i = 0; i < NUM_ADDR_OUT; i++) begin
      int p;
      p = FIRST_ADDR_OUT_PORT + i;
      latched_addr[i] = 8'hc3 ^ 8'(i);
      wr(OFS_PIN_DIRECTION[p], 8'h00);
      wr(OFS_ADDR_OUT_SELECT[i], 8'hf0);
      settle();
      check8(pin_out[p] & 8'hf0, (8'hc3 ^ 8'(i)) & 8'hf0);
      check8(pin_out[p] & 8'h0f, (8'h96 ^ 8'(p)) & 8'h0f);
      check8(pin_oe[p], 8'hf0);
    end
    $display("test_addr_out done");
  endtask : test_addr_out
  task automatic test_status();
    main_sector_prot = 8'ha5;
    secondary_sector_prot = 4'h9;
    security_set = 1'b1;
    rd_check(OFS_MAIN_LOCK, 8'ha5);
    rd_check(OFS_SECONDARY_LOCK, 8'h89);
    wr(OFS_MAIN_LOCK, 8'h00);
    wr(OFS_SECONDARY_LOCK, 8'h76);
    wr(OFS_SIZE_INFO_0, 8'hff);
    wr(OFS_PIN_INPUT[0], 8'hff);
    rd_check(OFS_OUTPUT_LATCH[0], 8'h55);
    rd_check(OFS_MAIN_LOCK, 8'ha5);
    rd_check(OFS_SECONDARY_LOCK, 8'h89);
    rd_check(OFS_SIZE_INFO_0, SIZE_INFO_0);
    rd_check(OFS_SIZE_INFO_1, SIZE_INFO_1);
    security_set = 1'b0;
    secondary_sector_prot = 4'h6;
    rd_check(OFS_SECONDARY_LOCK, 8'h06);
    $display("test_status done");
  endtask : test_status
  task automatic test_control();
    logic [7:0] got;
    wr(OFS_POWER_CONTROL_0, 8'hff);
    wr(OFS_POWER_CONTROL_2, 8'hff);
    wr(OFS_MEMORY_MAP, 8'hff);
    wr(OFS_PAGE_SELECT, 8'h5a);
    settle();
    check8(power_control_0, PC0_MASK);
    check8(power_control_2, PC2_MASK);
    check8({3'h0, memory_space_map}, MAP_MASK);
    check8(page_out, 8'h5a);
    rd_check(OFS_MEMORY_MAP, MAP_MASK);
    i_host_bus_model.write_byte({~BASE, OFS_PAGE_SELECT}, 8'h00);
    i_host_bus_model.read_byte({~BASE, OFS_PAGE_SELECT}, got);
    check8(got, 8'h00);
    rd_check(8'h02, 8'h00);
    rd_check(OFS_PAGE_SELECT, 8'h5a);
    arst_n = 1'b0;
    @(posedge sys_clk);
    #2;
    arst_n = 1'b1;
    check8(page_out, 8'h00);
    rd_check(OFS_POWER_CONTROL_0, 8'h00);
    $display("test_control done");
  endtask : test_control

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (12) @(posedge sys_clk);
    #2;
    arst_n = 1'b1;
    test_reset();
    test_ports();
    test_drive();
    test_addr_out();
    test_status();
    test_control();
    finish_test();
  end
  initial begin
    #1ms;
    fails++;
    finish_test();
  end
endmodule : io_config_register_bank_test
